// ### src/accel_restart.sv
// acceleration interface control, reference steering and temperature restart
// assumes apb on pclk, comparator levels asynchronous, converter status synchronous
//
// Operation
// - reference on channel two, powered while converting
// - control bits power element and capture output
// - trim registers hold while powered, rewritable
// - parity of trim bits checked continuously
// - even parity forces output to minimum
// - single chain, one axis per conversion
// - axis select: set is z, clear x
// - trim bit inverts z-axis polarity
// - optional two-pole low-pass filter control
// - falling below restart threshold resets mcu
// - reset only after arming above rearm
// - armed status at bit 0, reset sets
// - armed allows restart; clear forbids stop
// - enable bit 7 powers module, reset clears
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module accel_restart #(
  parameter int TRIM_COUNT = 4
) (
  // clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // apb slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [15:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output logic                                     pready,
  output logic [31:0]                              prdata,
  output logic                                     pslverr,
  // converter status
  input  wire logic                                conv_busy,
  input  wire logic [4:0]                          conv_channel,
  output logic                                     conv_trigger,
  output accel_restart_pkg::vref_ctrl_type         vref_ctrl,
  // acceleration front-end
  output accel_restart_pkg::accel_analog_type      accel_analog,
  output logic [TRIM_COUNT-1:0][7:0]               accel_trim,
  // temperature restart comparators and results
  input  wire logic                                temp_above_rearm,
  input  wire logic                                temp_below_reset,
  output logic                                     restart_power,
  output logic                                     restart_req,
  output logic                                     stop_permit
);

  // trim select is two bits wide, so exactly four trim registers can be served
  if (TRIM_COUNT != 4) begin : g_bad_trim_count
    $error("trim select is two bits wide, four trim registers needed");
  end

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [6:0]                       ctrl;
    logic [TRIM_COUNT-1:0][7:0]       trim;
    accel_restart_pkg::accel_analog_type accel;
    accel_restart_pkg::vref_ctrl_type vref;
    logic                             trigger;
    logic                             restart_en;
    logic                             armed;
    logic [1:0]                       rearm_sync;
    logic [1:0]                       reset_sync;
    logic                             restart_req;
    logic                             pready;
    logic                             pslverr;
    logic [31:0]                      prdata;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  // word address decode, used by read and write paths
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] idx);
    hit = (addr[1:0] == 2'b00) && (addr[15:2] == idx[13:0]);
  endfunction

  logic        setup;
  logic        wr_done;
  logic        mapped;
  logic [1:0]  trim_sel;
  logic        wr_trim;
  logic        wr_ctrl;
  logic        wr_opt;

  assign setup    = psel && !penable;
  assign wr_done  = psel && penable && s_r.pready && pwrite;
  assign mapped   = hit(paddr, accel_restart_pkg::IDX_SYSTEM_OPTIONS_TWO)
                 || hit(paddr, accel_restart_pkg::IDX_SYSTEM_TEST_STATUS)
                 || hit(paddr, accel_restart_pkg::IDX_ACCEL_CTRL_REG)
                 || hit(paddr, accel_restart_pkg::IDX_ACCEL_TRIM_DATA)
                 || hit(paddr, accel_restart_pkg::IDX_ACCEL_STATUS);
  assign trim_sel = s_r.ctrl[accel_restart_pkg::CTRL_TRIM_SEL_LSB +: 2];
  assign wr_ctrl  = wr_done && hit(paddr, accel_restart_pkg::IDX_ACCEL_CTRL_REG);
  assign wr_opt   = wr_done && hit(paddr, accel_restart_pkg::IDX_SYSTEM_OPTIONS_TWO);
  // trim writes only land when the direction bit says write
  assign wr_trim  = wr_done && hit(paddr, accel_restart_pkg::IDX_ACCEL_TRIM_DATA)
                 && s_r.ctrl[accel_restart_pkg::CTRL_TRIM_READ_WRITE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    logic [7:0] rd;
    rd    = 8'h00;
    s_nxt = s_r;
    // zero wait state: ready rises in the access phase
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup && !mapped;
    if (setup) begin
      if (hit(paddr, accel_restart_pkg::IDX_SYSTEM_OPTIONS_TWO)) begin
        rd[accel_restart_pkg::RESTART_POWER_ENABLE_BIT] = s_r.restart_en;
      end
      if (hit(paddr, accel_restart_pkg::IDX_SYSTEM_TEST_STATUS)) begin
        rd[accel_restart_pkg::RESTART_ARMED_STATUS_BIT] = s_r.armed;
      end
      if (hit(paddr, accel_restart_pkg::IDX_ACCEL_CTRL_REG)) begin
        rd = {1'b0, s_r.ctrl};
      end
      if (hit(paddr, accel_restart_pkg::IDX_ACCEL_TRIM_DATA)) begin
        rd = s_r.trim[trim_sel];
      end
      if (hit(paddr, accel_restart_pkg::IDX_ACCEL_STATUS)) begin
        rd[accel_restart_pkg::STATUS_PARITY_FAULT_BIT] = s_r.accel.force_min;
      end
      s_nxt.prdata = {24'h000000, rd};
    end
    // control register; trigger bit is a write-one pulse, never stored
    s_nxt.trigger = wr_ctrl && pwdata[accel_restart_pkg::CTRL_TRIGGER_BIT];
    if (wr_ctrl) begin
      s_nxt.ctrl = pwdata[6:0];
    end
    if (wr_opt) begin
      s_nxt.restart_en = pwdata[accel_restart_pkg::RESTART_POWER_ENABLE_BIT];
    end
    // trim storage lives on the interface supply: lost when unpowered
    if (!s_r.accel.power) begin
      s_nxt.trim = '0;
    end else if (wr_trim) begin
      s_nxt.trim[trim_sel] = pwdata[7:0];
    end
    // front-end steering; one axis bit means one chain
    s_nxt.accel.power     = s_r.ctrl[accel_restart_pkg::CTRL_POWER_BIT];
    s_nxt.accel.capture   = s_r.ctrl[accel_restart_pkg::CTRL_CAPTURE_BIT];
    s_nxt.accel.axis_z    = s_r.ctrl[accel_restart_pkg::CTRL_AXIS_SELECT_BIT];
    s_nxt.accel.filter_on = s_r.ctrl[accel_restart_pkg::CTRL_FILTER_BIT];
    s_nxt.accel.z_invert  = s_r.trim[accel_restart_pkg::TRIM_Z_INVERT_REG]
                                    [accel_restart_pkg::TRIM_Z_INVERT_BIT];
    // odd total parity is healthy; even parity pins the output low
    s_nxt.accel.force_min = ~(^s_r.trim);
    // reference powered through any conversion, steered to channel two
    s_nxt.vref.powered    = conv_busy;
    s_nxt.vref.to_channel = (conv_channel == accel_restart_pkg::CONV_CH_VREF);
    // two-stage synchronisers for the comparator levels
    s_nxt.rearm_sync = {s_r.rearm_sync[0], temp_above_rearm};
    s_nxt.reset_sync = {s_r.reset_sync[0], temp_below_reset};
    // restart hysteresis; arming wins if both comparators report at once
    s_nxt.restart_req = 1'b0;
    if (s_r.restart_en) begin
      if (s_r.reset_sync[1] && s_r.armed) begin
        s_nxt.restart_req = 1'b1;
        s_nxt.armed       = 1'b0;
      end
      if (s_r.rearm_sync[1]) begin
        s_nxt.armed = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; any mcu reset sets armed and clears enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r            <= '0;
      s_r.ctrl       <= accel_restart_pkg::CTRL_RESET;
      s_r.trim       <= {TRIM_COUNT{accel_restart_pkg::TRIM_RESET}};
      s_r.restart_en <= accel_restart_pkg::RESTART_EN_RESET;
      s_r.armed      <= accel_restart_pkg::ARMED_RESET;
      s_r.accel.force_min <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign pready        = s_r.pready;
  assign prdata        = s_r.prdata;
  assign pslverr       = s_r.pslverr;
  assign conv_trigger  = s_r.trigger;
  assign vref_ctrl     = s_r.vref;
  assign accel_analog  = s_r.accel;
  assign accel_trim    = s_r.trim;
  assign restart_power = s_r.restart_en;
  assign restart_req   = s_r.restart_req;
  assign stop_permit   = s_r.armed;

  ////////////////////////////////////////////////////////////////////////////
  property p_vref_busy;
    @(posedge pclk) disable iff (!presetn)
    conv_busy |=> vref_ctrl.powered;
  endproperty
  a_vref_busy: assert property (p_vref_busy)
    else $error("reference unpowered during conversion");

  property p_power_ctrl;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ##1 (accel_analog.power == $past(pwdata[0], 2));
  endproperty
  a_power_ctrl: assert property (p_power_ctrl)
    else $error("front-end power does not follow control write");

  property p_trim_hold;
    @(posedge pclk) disable iff (!presetn)
    (accel_analog.power && !wr_trim) |=> $stable(accel_trim);
  endproperty
  a_trim_hold: assert property (p_trim_hold)
    else $error("trim changed without a trim write");

  property p_parity_force;
    @(posedge pclk) disable iff (!presetn)
    ##1 (accel_analog.force_min == !(^$past(accel_trim)));
  endproperty
  a_parity_force: assert property (p_parity_force)
    else $error("output force does not track even trim parity");

  property p_parity_fault_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && hit(paddr, accel_restart_pkg::IDX_ACCEL_STATUS))
      |=> (prdata[0] == $past(accel_analog.force_min)) && (prdata[31:1] == 31'h0);
  endproperty
  a_parity_fault_read: assert property (p_parity_fault_read)
    else $error("parity fault status read wrong");

  property p_axis_sel;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ##1 (accel_analog.axis_z == $past(pwdata[2], 2));
  endproperty
  a_axis_sel: assert property (p_axis_sel)
    else $error("axis select not applied");

  property p_z_invert;
    @(posedge pclk) disable iff (!presetn)
    ##1 (accel_analog.z_invert == $past(accel_trim[3][7]));
  endproperty
  a_z_invert: assert property (p_z_invert)
    else $error("z polarity does not follow trim bit");

  property p_filter;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ##1 (accel_analog.filter_on == $past(pwdata[3], 2));
  endproperty
  a_filter: assert property (p_filter)
    else $error("filter control not applied");

  property p_restart_cause;
    @(posedge pclk) disable iff (!presetn)
    restart_req |-> $past(stop_permit) && !stop_permit && $past(restart_power)
                 && $past(temp_below_reset, 3);
  endproperty
  a_restart_cause: assert property (p_restart_cause)
    else $error("restart without arming or synchronised cause");

  property p_restart_fire;
    @(posedge pclk) disable iff (!presetn)
    (restart_power && stop_permit && s_r.reset_sync[1]) |=> restart_req;
  endproperty
  a_restart_fire: assert property (p_restart_fire)
    else $error("armed module missed a restart");

  property p_armed_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && hit(paddr, accel_restart_pkg::IDX_SYSTEM_TEST_STATUS))
      |=> (prdata == {31'h0, $past(stop_permit)});
  endproperty
  a_armed_read: assert property (p_armed_read)
    else $error("armed status read wrong");

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
    wr_opt |=> (restart_power == $past(pwdata[7]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("restart enable not written");

  property p_vref_channel;
    @(posedge pclk) disable iff (!presetn)
    (conv_channel == accel_restart_pkg::CONV_CH_VREF) |=> vref_ctrl.to_channel;
  endproperty
  a_vref_channel: assert property (p_vref_channel)
    else $error("reference not steered to channel two");

  property p_disabled_hold;
    @(posedge pclk) disable iff (!presetn)
    !restart_power |=> !restart_req && $stable(stop_permit);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("unpowered restart module acted");

endmodule

// ### src/accel_restart_pkg.sv
// constants, register map and carrier types of the sensor front-end control block
// assumes an apb master on the mcu bus clock; analog parts sit outside
package accel_restart_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SYSTEM_OPTIONS_TWO = 16'h1803;
  localparam logic [15:0] IDX_SYSTEM_TEST_STATUS = 16'h180F;
  localparam logic [15:0] IDX_ACCEL_CTRL_REG     = 16'h1810;
  localparam logic [15:0] IDX_ACCEL_TRIM_DATA    = 16'h1811;
  localparam logic [15:0] IDX_ACCEL_STATUS       = 16'h1812;
  // field positions
  localparam int RESTART_POWER_ENABLE_BIT = 7;
  localparam int RESTART_ARMED_STATUS_BIT = 0;
  localparam int CTRL_POWER_BIT           = 0;
  localparam int CTRL_CAPTURE_BIT         = 1;
  localparam int CTRL_AXIS_SELECT_BIT     = 2;
  localparam int CTRL_FILTER_BIT          = 3;
  localparam int CTRL_TRIM_READ_WRITE_BIT = 4;
  localparam int CTRL_TRIM_SEL_LSB        = 5;
  localparam int CTRL_TRIGGER_BIT         = 7;
  localparam int STATUS_PARITY_FAULT_BIT  = 0;
  localparam int TRIM_Z_INVERT_REG        = 3;
  localparam int TRIM_Z_INVERT_BIT        = 7;
  // converter channel wired to the internal reference
  localparam logic [4:0] CONV_CH_VREF = 5'h02;
  // reset values
  localparam logic [6:0] CTRL_RESET        = 7'h00;
  localparam logic [7:0] TRIM_RESET        = 8'h00;
  localparam logic       RESTART_EN_RESET  = 1'b0;
  localparam logic       ARMED_RESET       = 1'b1;

  // control lines toward the acceleration front-end
  typedef struct packed {
    logic power;
    logic capture;
    logic axis_z;
    logic filter_on;
    logic z_invert;
    logic force_min;
  } accel_analog_type;

  // internal reference steering
  typedef struct packed {
    logic powered;
    logic to_channel;
  } vref_ctrl_type;
endpackage

// ### verification/temp_conv_model.sv
// far-side model: temperature comparators and converter busy flag
// assumes the bench sets temperature in degrees and the converter channel
`timescale 1ns/1ps
module temp_conv_model #(
  parameter int REARM_LEVEL = 90,
  parameter int RESET_LEVEL = 80
) (
  // clock and stimulus
  input  wire logic       pclk,
  input  wire logic signed [31:0] temp,
  input  wire logic       conv_trigger,
  input  wire logic [4:0] ch_sel,
  // comparator levels and converter status
  output logic            temp_above_rearm,
  output logic            temp_below_reset,
  output logic            conv_busy,
  output logic [4:0]      conv_channel
);
  int busy_left = 0;
  // levels move off the clock grid so the design must resynchronise them
  assign #13 temp_above_rearm = (temp > REARM_LEVEL);
  assign #13 temp_below_reset = (temp < RESET_LEVEL);
  ////////////////////////////////////////////////////////////////////////////
  // a trigger starts a six-cycle conversion on the selected channel
  always @(posedge pclk) begin
    if (conv_trigger === 1'b1) busy_left <= 6;
    else if (busy_left > 0) busy_left <= busy_left - 1;
  end
  assign conv_busy    = (busy_left > 0);
  assign conv_channel = ch_sel;
endmodule

// ### verification/accel_restart_tb.sv
// self-checking bench of the sensor front-end control block
// assumes the far-side model file; apb master and model values kept here
`timescale 1ns/1ps
module accel_restart_tb;
  localparam logic [15:0] OPT2 = accel_restart_pkg::IDX_SYSTEM_OPTIONS_TWO;
  localparam logic [15:0] TST  = accel_restart_pkg::IDX_SYSTEM_TEST_STATUS;
  localparam logic [15:0] CTRL = accel_restart_pkg::IDX_ACCEL_CTRL_REG;
  localparam logic [15:0] TRIM = accel_restart_pkg::IDX_ACCEL_TRIM_DATA;
  localparam logic [15:0] STAT = accel_restart_pkg::IDX_ACCEL_STATUS;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata, r;
  logic        pready, pslverr, conv_busy, conv_trigger, e;
  logic        temp_above_rearm, temp_below_reset, restart_power, restart_req, stop_permit;
  logic [4:0]  conv_channel, ch_sel = 5'h00;
  logic [7:0]  v, tm[4];
  logic [3:0][7:0]                     accel_trim;
  accel_restart_pkg::vref_ctrl_type    vref_ctrl;
  accel_restart_pkg::accel_analog_type accel_analog;
  int          temp = 100, failures = 0, n_checks = 0, n_restart = 0, n_trig = 0;
  logic [31:0] seed = 32'hF9BB;

  always #50 pclk = ~pclk;
  // pulse counters; both outputs stand one cycle only
  always @(posedge pclk) begin
    n_restart += (restart_req === 1'b1);
    n_trig += (conv_trigger === 1'b1);
  end
  accel_restart #(.TRIM_COUNT(4)) accel_restart_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .conv_busy(conv_busy),
    .conv_channel(conv_channel), .conv_trigger(conv_trigger), .vref_ctrl(vref_ctrl),
    .accel_analog(accel_analog), .accel_trim(accel_trim), .temp_above_rearm(temp_above_rearm),
    .temp_below_reset(temp_below_reset), .restart_power(restart_power),
    .restart_req(restart_req), .stop_permit(stop_permit));
  temp_conv_model temp_conv_model_inst (.pclk(pclk), .temp(temp), .conv_trigger(conv_trigger),
    .ch_sel(ch_sel), .temp_above_rearm(temp_above_rearm),
    .temp_below_reset(temp_below_reset), .conv_busy(conv_busy), .conv_channel(conv_channel));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x, input string m);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic chk_bit(input logic g, input logic x, input string m);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("mismatch t=%0t %s got %b exp %b", $time, m, g, x);
    end
  endtask
  // one apb transfer; the wait for pready is polled without a bound, never assumed
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= idx << 2;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    // the slave answers with no wait state; only the watchdog ends a hang
    chk_bit(k == 1, 1'b1, "wait states");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] x, input string m);
    apb(1'b0, idx, 8'h00);
    chk_reg(r, {24'h000000, x}, m);
  endtask
  // select a trim register, optionally writing it; power stays on to keep trims
  task automatic trim_wr(input int s, input logic [7:0] d, input logic en);
    apb(1'b1, CTRL, 8'h01 | {1'b0, s[1:0], en, 4'h0});
    if (en) apb(1'b1, TRIM, d);
  endtask
  task automatic heat(input int t);
    temp <= t;
    repeat (8) @(posedge pclk);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    chk_bit(1'b0, 1'b1, "watchdog expired");
    conclude();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OPT2, 8'h00, "enable after reset");
    rd(TST, 8'h01, "armed after reset");
    rd(STAT, 8'h01, "parity after reset");
    // front-end control bits, random patterns
    for (int i = 0; i < 4; i++) begin
      v = 8'(rnd() & 32'h0000000F);
      apb(1'b1, CTRL, v);
      repeat (3) @(posedge pclk);
      chk_reg({28'h0, accel_analog.filter_on, accel_analog.axis_z, accel_analog.capture,
               accel_analog.power}, {24'h0, v}, "front-end lines");
      rd(CTRL, v, "ctrl readback");
    end
    // trim load with odd parity, then a refused write
    for (int i = 0; i < 4; i++) tm[i] = 8'(rnd());
    if (^{tm[0], tm[1], tm[2], tm[3]} == 1'b0) tm[0][0] = ~tm[0][0];
    for (int i = 0; i < 4; i++) trim_wr(i, tm[i], 1'b1);
    // direction bit cleared first, so this write must be ignored
    trim_wr(2, 8'h00, 1'b0);
    apb(1'b1, TRIM, ~tm[2]);
    for (int i = 0; i < 4; i++) begin
      trim_wr(i, 8'h00, 1'b0);
      rd(TRIM, tm[i], "trim readback");
      chk_reg({24'h0, accel_trim[i]}, {24'h0, tm[i]}, "trim lines");
    end
    chk_bit(accel_analog.force_min, 1'b0, "odd parity");
    chk_bit(accel_analog.z_invert, tm[3][7], "z polarity");
    trim_wr(3, tm[3] ^ 8'hC0, 1'b1);
    repeat (2) @(posedge pclk);
    chk_bit(accel_analog.z_invert, ~tm[3][7], "z polarity flip");
    trim_wr(1, tm[1] ^ 8'h01, 1'b1);
    repeat (2) @(posedge pclk);
    chk_bit(accel_analog.force_min, 1'b1, "even parity");
    rd(STAT, 8'h01, "parity fault flag");
    trim_wr(1, tm[1], 1'b1);
    repeat (2) @(posedge pclk);
    chk_bit(accel_analog.force_min, 1'b0, "reloaded trims");
    // conversions on the reference channel and another
    for (int c = 2; c <= 5; c += 3) begin
      ch_sel <= c[4:0];
      apb(1'b1, CTRL, 8'h81);
      repeat (3) @(posedge pclk);
      chk_bit(vref_ctrl.powered, 1'b1, "reference powered");
      chk_bit(vref_ctrl.to_channel, c == 2, "reference steering");
      repeat (10) @(posedge pclk);
      chk_bit(vref_ctrl.powered, 1'b0, "reference idle");
      rd(CTRL, 8'h01, "trigger reads zero");
    end
    chk_reg(n_trig, 2, "trigger pulses");
    // restart with hysteresis
    apb(1'b1, OPT2, 8'h80);
    rd(OPT2, 8'h80, "enable readback");
    chk_bit(restart_power, 1'b1, "restart powered");
    heat(50);
    chk_reg(n_restart, 1, "restart on cooling");
    chk_bit(stop_permit, 1'b0, "disarmed");
    rd(TST, 8'h00, "armed flag clear");
    heat(85);
    heat(50);
    chk_reg(n_restart, 1, "no restart unarmed");
    heat(100);
    chk_bit(stop_permit, 1'b1, "rearmed");
    // software shutdown may only enter deepest stop while the flag allows it
    chk_bit(stop_permit, 1'b1, "stop allowed for shutdown");
    heat(85);
    heat(50);
    chk_reg(n_restart, 2, "second restart");
    apb(1'b1, OPT2, 8'h00);
    heat(100);
    chk_bit(stop_permit, 1'b0, "no arming when off");
    heat(50);
    chk_reg(n_restart, 2, "no restart when off");
    // unmapped place, then a second reset
    apb(1'b1, 16'h1820, 8'hFF);
    chk_bit(e, 1'b1, "unmapped error");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(TST, 8'h01, "armed after second reset");
    rd(OPT2, 8'h00, "enable after second reset");
    conclude();
  end
endmodule
